/* File: dv/tb_top.sv */
// self-checking bench of the wave timer: registers, clock select, modes, forced matches
// assumes the design, its checker bind and the pin model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic port_v = 1'b0;
   logic win = 1'b0;
   logic [7:0] d, v;
   logic [31:0] r;
   logic [31:0] seed = 32'h0000_001F;
   wire [7:0] reg_rdata;
   wire ext_pin, wave_out_a, wave_en_a, wave_out_b, wave_en_b;
   wire overflow_flag, match_a_pulse, match_b_pulse;
   integer mismatches = 0;
   integer comparisons = 0;
   integer n_hi, n_ov, n_ma, n_mb, i, k;
   integer divs [0:5] = '{1, 1, 8, 64, 256, 1024};
   logic [7:0] masks [0:5] = '{8'hF3, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   tmr_wave i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_pin(ext_pin),
      .wave_out_a(wave_out_a), .wave_en_a(wave_en_a), .wave_out_b(wave_out_b),
      .wave_en_b(wave_en_b), .overflow_flag(overflow_flag), .match_a_pulse(match_a_pulse),
      .match_b_pulse(match_b_pulse));
   tmr_pin_model i_pin (.core_clk(core_clk), .dir_out(1'b1), .port_val(port_v),
      .wave_en(1'b0), .wave_out(1'b0), .pin(ext_pin));
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic near(input logic [31:0] n, input integer e, input integer t);
      return (n >= e - t) && (n <= e + t);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // a gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      reg_addr <= a;
      reg_wdata <= dv;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
      @(posedge core_clk);
   endtask
   // force bits zero on pwm writes
   task automatic setup(input logic [7:0] c0, ca, cb, fa, fb);
      wr(8'h25, 8'h00);
      wr(8'h24, 8'h00);
      wr(8'h26, c0);
      wr(8'h27, ca);
      wr(8'h28, cb);
      wr(8'h24, fa);
      wr(8'h25, fb);
   endtask
   task automatic run(input integer n);
      #1;
      n_hi = 0;
      n_ov = 0;
      n_ma = 0;
      n_mb = 0;
      win = 1'b1;
      repeat (n) @(posedge core_clk);
      #1 win = 1'b0;
   endtask
   always @(posedge core_clk) begin
      if (win) begin
         n_hi = n_hi + (wave_out_b === 1'b1);
         n_ov = n_ov + (overflow_flag === 1'b1);
         n_ma = n_ma + (match_a_pulse === 1'b1);
         n_mb = n_mb + (match_b_pulse === 1'b1);
      end
   end
   initial begin
      #400_000;
      mismatches = mismatches + 1;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (i = 0; i < 6; i = i + 1) begin
         rd(8'h24 + i[7:0], d);
         chk(d, 8'h00);
      end
      for (k = 0; k < 4; k = k + 1) begin
         for (i = 0; i < 6; i = i + 1) begin
            r = xs();
            v = (i == 1) ? (r[7:0] & 8'hF8) : r[7:0];
            wr(8'h24 + i[7:0], v);
            rd(8'h24 + i[7:0], d);
            chk(d, v & masks[i]);
         end
      end
      for (i = 1; i < 6; i = i + 1) begin
         setup(8'h00, 8'h00, 8'h00, 8'h00, i[7:0]);
         run(divs[i] * 20);
         rd(8'h26, d);
         chk(near(d, 20, 3), 1'b1);
      end
      for (i = 6; i < 8; i = i + 1) begin
         setup(8'h00, 8'h00, 8'h00, 8'h00, i[7:0]);
         repeat (10) begin
            port_v <= 1'b1;
            repeat (8) @(posedge core_clk);
            port_v <= 1'b0;
            repeat (8) @(posedge core_clk);
         end
         repeat (8) @(posedge core_clk);
         rd(8'h26, d);
         chk(d, 8'h0A);
      end
      setup(8'h00, 8'h00, 8'h00, 8'hA0, 8'h00);
      wr(8'h25, 8'hC0);
      #1 chk({wave_out_a, wave_out_b}, 2'h0);
      wr(8'h24, 8'h50);
      wr(8'h25, 8'hC0);
      #1 chk({wave_out_a, wave_out_b}, 2'h3);
      wr(8'h24, 8'h60);
      wr(8'h25, 8'hC0);
      #1 chk({wave_out_a, wave_out_b}, 2'h0);
      setup(8'h00, 8'h05, 8'h07, 8'h70, 8'h01);
      run(600);
      chk(n_ov[15:0], 16'd2);
      chk(n_ma[15:0], 16'd3);
      chk({wave_out_a, wave_out_b, wave_en_b}, 3'h7);
      setup(8'h05, 8'h05, 8'h07, 8'h70, 8'h01);
      run(100);
      chk({n_ma[3:0], n_mb[3:0]}, 8'h01);
      setup(8'h00, 8'h09, 8'h00, 8'h42, 8'h01);
      run(300);
      chk({near(n_ma, 30, 1), n_ov[3:0]}, 5'h10);
      setup(8'h00, 8'h00, 8'h40, 8'h23, 8'h01);
      run(2560);
      chk({near(n_hi, 650, 6), near(n_ov, 10, 1)}, 2'h3);
      setup(8'h00, 8'h3F, 8'h3F, 8'h23, 8'h09);
      run(100);
      run(640);
      chk(n_hi[15:0], 16'd640);
      chk(near(n_ov, 10, 1), 1'b1);
      setup(8'h00, 8'h00, 8'h40, 8'h21, 8'h01);
      run(600);
      run(5100);
      chk({near(n_hi, 1280, 8), near(n_ov, 10, 1)}, 2'h3);
      setup(8'h00, 8'h20, 8'h20, 8'h21, 8'h09);
      run(200);
      run(640);
      chk(n_hi[15:0], 16'd640);
      chk(near(n_ov, 10, 1), 1'b1);
      wr(8'h25, 8'h08);
      repeat (2) @(posedge core_clk);
      wr(8'h25, 8'hC8);
      #1 chk(wave_out_b, 1'b1);
      wr(8'h24, 8'h00);
      #1 chk({wave_en_a, wave_en_b}, 2'h0);
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire

/* File: dv/tmr_pin_model.sv */
// port pin model: one port bit with direction, level and waveform override
// assumes the bench drives direction and level; a released pin toggles on every rising core clock edge
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
   input wire core_clk,
   input wire dir_out,
   input wire port_val,
   input wire wave_en,
   input wire wave_out,
   output logic pin
);
   initial pin = 1'b0;
   always @(posedge core_clk) begin
      if (!dir_out) pin <= ~pin;
      else if (wave_en) pin <= wave_out;
      else pin <= port_val;
   end
endmodule // tmr_pin_model
`default_nettype wire

/* File: dv/tmr_wave_asserts.sv */
// port checker of the wave timer: register reads, pin enables, clock stop, forced matches
// assumes a bind onto tmr_wave, one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tmr_wave_asserts (
   input wire core_clk,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire ext_count_pin,
   input wire wave_out_a,
   input wire wave_en_a,
   input wire wave_out_b,
   input wire wave_en_b,
   input wire overflow_flag,
   input wire match_a_pulse,
   input wire match_b_pulse
);
   reg [7:0] ctl_a_r;
   reg [2:0] cs_r;
   wire wr_a = reg_wr && reg_addr == 8'h24;
   wire wr_b = reg_wr && reg_addr == 8'h25;
   wire wr_c = reg_wr && reg_addr == 8'h26;
   wire rd_a = reg_rd && reg_addr == 8'h24;
   wire rd_b = reg_rd && reg_addr == 8'h25;
   wire rd_c = reg_rd && reg_addr == 8'h26;
   wire quiet = cs_r == 3'h0;
   wire frc_a = wr_b && (reg_wdata & 8'h87) == 8'h80 && !ctl_a_r[0] && ctl_a_r[7:6] == 2'h1;
   wire frc_b = wr_b && (reg_wdata & 8'h47) == 8'h40 && !ctl_a_r[0] && ctl_a_r[5:4] == 2'h1;
   wire frc_p = wr_b && reg_wdata[7:6] != 2'h0 && reg_wdata[2:0] == 3'h0 && ctl_a_r[0];
   // shadows of the last control writes, to know mode and clock source
   always @(posedge core_clk) begin
      if (rst) begin
         ctl_a_r <= 8'h00;
         cs_r <= 3'h0;
      end else begin
         if (wr_a) ctl_a_r <= reg_wdata;
         if (wr_b) cs_r <= reg_wdata[2:0];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_ctla_gap_zero: assert property (
      $past(rd_a) |-> reg_rdata[3:2] == 2'h0) else $error("control A gap bits set");
   a_ctlb_top_zero: assert property (
      $past(rd_b) |-> reg_rdata[7:4] == 4'h0) else $error("control B upper bits set");
   // the enable is registered from the stored control byte, so it shows two edges after the write
   a_pin_b_enable: assert property (
      $past(wr_a) |=> wave_en_b == (($past(reg_wdata, 2) & 8'h30) != 8'h00))
      else $error("wave B enable wrong");
   a_pin_a_enable: assert property (
      $past(wr_a) |=> wave_en_a == (($past(reg_wdata, 2) & 8'hC0) != 8'h00))
      else $error("wave A enable wrong");
   // a tick already registered may still land two edges after the stop
   a_stop_is_silent: assert property (
      quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3)
      |-> !overflow_flag && !match_a_pulse && !match_b_pulse) else $error("event while stopped");
   a_force_a_acts: assert property (
      frc_a && quiet && $past(quiet) ##1 !wr_a |=> wave_out_a != $past(wave_out_a, 2))
      else $error("forced A had no effect");
   a_force_b_acts: assert property (
      frc_b && quiet && $past(quiet) ##1 !wr_a |=> wave_out_b != $past(wave_out_b, 2))
      else $error("forced B had no effect");
   a_force_pwm_none: assert property (
      frc_p && quiet && $past(quiet) && $past(quiet, 2)
      |=> ($stable(wave_out_a) && $stable(wave_out_b)) [*2]) else $error("force acted in pwm");
   a_count_readback: assert property (
      wr_c && quiet && $past(quiet) ##2 (rd_c && quiet) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("count readback wrong");
endmodule // tmr_wave_asserts
bind tmr_wave tmr_wave_asserts i_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ext_count_pin(ext_count_pin), .wave_out_a(wave_out_a), .wave_en_a(wave_en_a),
   .wave_out_b(wave_out_b), .wave_en_b(wave_en_b), .overflow_flag(overflow_flag),
   .match_a_pulse(match_a_pulse), .match_b_pulse(match_b_pulse));
`default_nettype wire

/* File: logic/tmr_regs.vh */
// register offsets, field positions, codes and reset values of the 8-bit wave timer
// assumes inclusion by bare name from the timer design file
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

`define TMR_OFS_CTRL_A 8'h24
`define TMR_OFS_CTRL_B 8'h25
`define TMR_OFS_COUNT 8'h26
`define TMR_OFS_CMP_A 8'h27
`define TMR_OFS_CMP_B 8'h28

`define TMR_RST_BYTE 8'h00
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_ONE 8'h01

// control A fields
`define TMR_A_ACT_HI 7
`define TMR_A_ACT_LO 6
`define TMR_B_ACT_HI 5
`define TMR_B_ACT_LO 4
`define TMR_MODE_LO_HI 1
`define TMR_MODE_LO_LO 0
`define TMR_CTRL_A_MASK 8'hF3

// control B fields
`define TMR_FORCE_A 7
`define TMR_FORCE_B 6
`define TMR_MODE_HI 3
`define TMR_CS_HI 2
`define TMR_CS_LO 0
`define TMR_CTRL_B_MASK 8'h0F

// waveform modes
`define TMR_MODE_NORMAL 3'h0
`define TMR_MODE_PC_MAX 3'h1
`define TMR_MODE_CTC 3'h2
`define TMR_MODE_FAST_MAX 3'h3
`define TMR_MODE_PC_CMP 3'h5
`define TMR_MODE_FAST_CMP 3'h7

// output actions
`define TMR_ACT_OFF 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3

// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

// prescaler taps: a tick fires when all low bits of the divider are ones
`define TMR_PRE_W 10
`define TMR_PRE_ZERO 10'h000
`define TMR_PRE_ONE 10'h001
`define TMR_PRE_M8 10'h007
`define TMR_PRE_M64 10'h03F
`define TMR_PRE_M256 10'h0FF
`define TMR_PRE_M1024 10'h3FF

`endif

/* File: logic/tmr_wave.v */
// 8-bit timer/counter with two compare channels, waveform modes and clock select
// assumes a single core clock, synchronous reset, and a cpu port with read data one cycle later
//
// Behaviour
// RL1 - nonzero B action routes wave B to pin
// RL2 - software sets pin direction for wave B
// RL3 - non-pwm B: off, toggle, clear, set
// RL4 - fast pwm B: clear/set on match, opposite at bottom
// RL5 - fast pwm compare equals top: only bottom action
// RL6 - phase pwm B: up-match and down-match act oppositely
// RL7 - phase pwm compare equals top: act at top
// RL8 - unused control bits read as zero
// RL9 - three-bit mode from both control registers
// RL10 - top is max or compare A by mode
// RL11 - compare update and overflow point by mode
// RL12 - force strobe applies match in non-pwm modes
// RL13 - software writes force bits zero in pwm
// RL14 - forced match: no flag, no counter clear
// RL15 - force bits read as zero
// RL16 - clock select: stop, dividers, external edges
// RL17 - external pin counts even when output
// RL18 - counter register read and write
// RL19 - counter write blocks next tick match
// RL20 - compare A checked against counter continuously
// RL21 - channel A toggles in pwm with mode_hi
// RL22 - phase pwm holds top one tick, reverses
// RL23 - single-slope modes wrap top to bottom
// RL24 - prescaler makes one-cycle count enable
`timescale 1ns/1ps
`include "tmr_regs.vh"
`default_nettype none

module tmr_wave (
   input wire core_clk,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   input wire ext_count_pin,
   output wire wave_out_a,
   output wire wave_en_a,
   output wire wave_out_b,
   output wire wave_en_b,
   output wire overflow_flag,
   output wire match_a_pulse,
   output wire match_b_pulse
);

   function is_pc;
      input [2:0] m;
      begin
         is_pc = (m == `TMR_MODE_PC_MAX) || (m == `TMR_MODE_PC_CMP);
      end
   endfunction

   function is_fast;
      input [2:0] m;
      begin
         is_fast = (m == `TMR_MODE_FAST_MAX) || (m == `TMR_MODE_FAST_CMP);
      end
   endfunction

   function top_is_cmp;
      input [2:0] m;
      begin
         top_is_cmp = (m == `TMR_MODE_CTC) || (m == `TMR_MODE_PC_CMP) ||
            (m == `TMR_MODE_FAST_CMP);
      end
   endfunction

   reg [7:0] ctrl_a_r;
   reg [3:0] ctrl_b_r;
   reg [7:0] cnt_r;
   reg dir_down_r;
   reg block_r;
   reg [7:0] cmp_buf_a_r;
   reg [7:0] cmp_buf_b_r;
   reg [7:0] cmp_act_a_r;
   reg [7:0] cmp_act_b_r;
   reg [1:0] force_r;
   reg [7:0] rdata_r;
   reg ovf_r;
   reg [1:0] match_r;
   reg [`TMR_PRE_W-1:0] pre_r;
   reg tick_r;
   reg tick_nxt;
   reg ext_s1_r;
   reg ext_s2_r;
   reg ext_s3_r;

   // RL9 mode assembly
   wire [2:0] mode = {ctrl_b_r[`TMR_MODE_HI], ctrl_a_r[`TMR_MODE_LO_HI:`TMR_MODE_LO_LO]};
   wire [2:0] cs = ctrl_b_r[`TMR_CS_HI:`TMR_CS_LO];
   wire pc_mode = is_pc(mode);
   wire pwm_mode = pc_mode | is_fast(mode);
   // RL10 top source
   wire [7:0] top = top_is_cmp(mode) ? cmp_act_a_r : `TMR_MAX;
   wire at_top = (cnt_r == top);
   wire at_bot = (cnt_r == `TMR_BOTTOM);

   wire wr_ctrl_a = reg_wr && (reg_addr == `TMR_OFS_CTRL_A);
   wire wr_ctrl_b = reg_wr && (reg_addr == `TMR_OFS_CTRL_B);
   wire wr_count = reg_wr && (reg_addr == `TMR_OFS_COUNT);
   wire wr_cmp_a = reg_wr && (reg_addr == `TMR_OFS_CMP_A);
   wire wr_cmp_b = reg_wr && (reg_addr == `TMR_OFS_CMP_B);

   // RL20 continuous compare, gated by the count enable
   wire hit_a = tick_r && !block_r && (cnt_r == cmp_act_a_r);
   wire hit_b = tick_r && !block_r && (cnt_r == cmp_act_b_r);

   // RL17 pin sampled regardless of its direction; first stage feeds only the second
   always @(posedge core_clk) begin
      if (rst) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_count_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // RL16 clock source decode
   always @* begin
      tick_nxt = 1'b0;
      case (cs)
         `TMR_CS_STOP: tick_nxt = 1'b0;
         `TMR_CS_DIV1: tick_nxt = 1'b1;
         `TMR_CS_DIV8: tick_nxt = ((pre_r & `TMR_PRE_M8) == `TMR_PRE_M8);
         `TMR_CS_DIV64: tick_nxt = ((pre_r & `TMR_PRE_M64) == `TMR_PRE_M64);
         `TMR_CS_DIV256: tick_nxt = ((pre_r & `TMR_PRE_M256) == `TMR_PRE_M256);
         `TMR_CS_DIV1024: tick_nxt = ((pre_r & `TMR_PRE_M1024) == `TMR_PRE_M1024);
         `TMR_CS_EXT_FALL: tick_nxt = ext_s3_r && !ext_s2_r;
         `TMR_CS_EXT_RISE: tick_nxt = ext_s2_r && !ext_s3_r;
         default: tick_nxt = 1'b0;
      endcase
   end

   // RL24 one-cycle count enable; divider free-runs so ticks stay evenly spaced
   always @(posedge core_clk) begin
      if (rst) begin
         pre_r <= `TMR_PRE_ZERO;
         tick_r <= 1'b0;
      end else begin
         pre_r <= pre_r + `TMR_PRE_ONE;
         tick_r <= tick_nxt;
      end
   end

   // control registers; reserved bits are never stored
   always @(posedge core_clk) begin
      if (rst) begin
         ctrl_a_r <= `TMR_RST_BYTE;
         ctrl_b_r <= 4'h0;
         force_r <= 2'b00;
      end else begin
         if (wr_ctrl_a) begin
            ctrl_a_r <= reg_wdata & `TMR_CTRL_A_MASK;
         end
         if (wr_ctrl_b) begin
            ctrl_b_r <= reg_wdata[`TMR_MODE_HI:`TMR_CS_LO];
         end
         // RL12 force strobes only in non-pwm modes
         force_r[0] <= wr_ctrl_b && reg_wdata[`TMR_FORCE_A] && !pwm_mode;
         force_r[1] <= wr_ctrl_b && reg_wdata[`TMR_FORCE_B] && !pwm_mode;
      end
   end

   // compare buffers and the active values the comparator uses
   always @(posedge core_clk) begin
      if (rst) begin
         cmp_buf_a_r <= `TMR_RST_BYTE;
         cmp_buf_b_r <= `TMR_RST_BYTE;
         cmp_act_a_r <= `TMR_RST_BYTE;
         cmp_act_b_r <= `TMR_RST_BYTE;
      end else begin
         if (wr_cmp_a) begin
            cmp_buf_a_r <= reg_wdata;
         end
         if (wr_cmp_b) begin
            cmp_buf_b_r <= reg_wdata;
         end
         // RL11 update point by mode
         if ((!pwm_mode) || (tick_r && at_top && mode != `TMR_MODE_FAST_CMP) ||
             (tick_r && at_bot && mode == `TMR_MODE_FAST_CMP)) begin
            cmp_act_a_r <= cmp_buf_a_r;
            cmp_act_b_r <= cmp_buf_b_r;
         end
      end
   end

   // counter
   always @(posedge core_clk) begin
      if (rst) begin
         cnt_r <= `TMR_RST_BYTE;
         dir_down_r <= 1'b0;
         block_r <= 1'b0;
      end else if (wr_count) begin
         // RL18 direct write
         cnt_r <= reg_wdata;
         // RL19 block the match on the following tick
         block_r <= 1'b1;
      end else if (tick_r) begin
         block_r <= 1'b0;
         if (pc_mode) begin
            // RL22 dual slope, one tick at each turning point
            if (!dir_down_r) begin
               if (at_top) begin
                  dir_down_r <= 1'b1;
                  cnt_r <= cnt_r - `TMR_ONE;
               end else begin
                  cnt_r <= cnt_r + `TMR_ONE;
               end
            end else begin
               if (at_bot) begin
                  dir_down_r <= 1'b0;
                  cnt_r <= cnt_r + `TMR_ONE;
               end else begin
                  cnt_r <= cnt_r - `TMR_ONE;
               end
            end
         end else begin
            dir_down_r <= 1'b0;
            // RL23 wrap at top; forced matches never reach here
            if (at_top) begin
               cnt_r <= `TMR_BOTTOM;
            end else begin
               cnt_r <= cnt_r + `TMR_ONE;
            end
         end
      end
   end

   // overflow and match event pulses
   always @(posedge core_clk) begin
      if (rst) begin
         ovf_r <= 1'b0;
         match_r <= 2'b00;
      end else begin
         // RL11 overflow point by mode
         if (pc_mode) begin
            ovf_r <= tick_r && dir_down_r && at_bot;
         end else if (mode == `TMR_MODE_FAST_CMP) begin
            ovf_r <= tick_r && at_top;
         end else begin
            ovf_r <= tick_r && (cnt_r == `TMR_MAX);
         end
         // RL14 forced matches raise no event
         match_r[0] <= hit_a;
         match_r[1] <= hit_b;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
         wire [1:0] act = (ch == 0) ? ctrl_a_r[`TMR_A_ACT_HI:`TMR_A_ACT_LO] :
            ctrl_a_r[`TMR_B_ACT_HI:`TMR_B_ACT_LO];
         wire hit = (ch == 0) ? hit_a : hit_b;
         wire [7:0] cmp = (ch == 0) ? cmp_act_a_r : cmp_act_b_r;
         wire cmp_top = (cmp == top);
         // RL21 toggle in pwm exists only on channel A with mode_hi
         wire pwm_tgl = (ch == 0) && (act == `TMR_ACT_TOGGLE) && ctrl_b_r[`TMR_MODE_HI];
         reg wave_r;
         reg en_r;
         always @(posedge core_clk) begin
            if (rst) begin
               wave_r <= 1'b0;
               en_r <= 1'b0;
            end else begin
               // RL1 pin override while action is nonzero
               en_r <= (act != `TMR_ACT_OFF);
               if (!pwm_mode) begin
                  // RL3 non-pwm actions, RL12 force acts like a match
                  if (hit || force_r[ch]) begin
                     case (act)
                        `TMR_ACT_TOGGLE: wave_r <= !wave_r;
                        `TMR_ACT_CLEAR: wave_r <= 1'b0;
                        `TMR_ACT_SET: wave_r <= 1'b1;
                        default: wave_r <= wave_r;
                     endcase
                  end
               end else if (act[1]) begin
                  if (!pc_mode) begin
                     // RL4 match action then opposite at bottom
                     // RL5 compare at top leaves only the bottom action
                     if (hit && !cmp_top) begin
                        wave_r <= act[0];
                     end else if (tick_r && at_top) begin
                        wave_r <= !act[0];
                     end
                  end else begin
                     // RL7 compare at top: act at the top turn
                     if (cmp_top) begin
                        if (tick_r && at_top) begin
                           wave_r <= !act[0];
                        end
                     // RL6 direction picks the action
                     end else if (hit) begin
                        wave_r <= dir_down_r ? !act[0] : act[0];
                     end
                  end
               end else if (pwm_tgl && hit) begin
                  wave_r <= !wave_r;
               end
            end
         end
      end
   endgenerate

   // read port; unmapped addresses answer zero
   always @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= `TMR_RST_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            // RL8 reserved bits read zero
            `TMR_OFS_CTRL_A: rdata_r <= ctrl_a_r & `TMR_CTRL_A_MASK;
            // RL15 force bits never stored, read zero
            `TMR_OFS_CTRL_B: rdata_r <= {4'h0, ctrl_b_r};
            `TMR_OFS_COUNT: rdata_r <= cnt_r;
            `TMR_OFS_CMP_A: rdata_r <= cmp_buf_a_r;
            `TMR_OFS_CMP_B: rdata_r <= cmp_buf_b_r;
            default: rdata_r <= `TMR_RST_BYTE;
         endcase
      end else begin
         rdata_r <= `TMR_RST_BYTE;
      end
   end

   assign reg_rdata = rdata_r;
   assign wave_out_a = g_ch[0].wave_r;
   assign wave_en_a = g_ch[0].en_r;
   assign wave_out_b = g_ch[1].wave_r;
   assign wave_en_b = g_ch[1].en_r;
   assign overflow_flag = ovf_r;
   assign match_a_pulse = match_r[0];
   assign match_b_pulse = match_r[1];

endmodule // tmr_wave

`default_nettype wire
